/* rtl/crcctl_pkg.sv */
package crcctl_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses on the peripheral bus)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_DMA_IER    = 8'h14;
    localparam logic [7:0] OFF_DMA_IDR    = 8'h18;
    localparam logic [7:0] OFF_DMA_IMR    = 8'h1c;
    localparam logic [7:0] OFF_DMA_ISR    = 8'h20;
    localparam logic [7:0] OFF_COMMAND    = 8'h34;
    localparam logic [7:0] OFF_CONFIG     = 8'h38;
    localparam logic [7:0] OFF_RESULT     = 8'h3c;
    localparam logic [7:0] OFF_ERR_IER    = 8'h40;
    localparam logic [7:0] OFF_ERR_IDR    = 8'h44;
    localparam logic [7:0] OFF_ERR_IMR    = 8'h48;
    localparam logic [7:0] OFF_ERR_ISR    = 8'h4c;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int          BIT_ENABLE    = 0;
    localparam int          BIT_COMPARE   = 1;
    localparam int          POLY_LSB      = 2;
    localparam int          DIV_LSB       = 4;
    localparam int          CMD_RELOAD    = 0;
    localparam int          MASK_BIT      = 0;
    localparam logic [7:0]  CONFIG_RESET  = 8'h00;
    localparam logic [31:0] RESULT_INIT   = 32'h0fffffff;

    // ----------------------------------------------------------------
    // polynomials, normal bit order
    // ----------------------------------------------------------------
    localparam logic [31:0] POLY_ETHERNET32  = 32'h04c11db7;
    localparam logic [31:0] POLY_ISCSI32     = 32'h1edc6f41;
    localparam logic [15:0] POLY_SIXTEEN_BIT = 16'h1021;

    typedef enum logic [1:0] {
        SEL_ETHERNET32  = 2'h0,
        SEL_ISCSI32     = 2'h1,
        SEL_SIXTEEN_BIT = 2'h2
    } crcctl_poly_t;

    typedef enum logic [1:0] {
        WIDTH_BYTE = 2'h0,
        WIDTH_HALF = 2'h1,
        WIDTH_WORD = 2'h2
    } crcctl_width_t;

endpackage : crcctl_pkg

/* rtl/crcctl_engine.sv */
`timescale 1ns/1ps

// one data item folded into the running checksum, lsb first
module crcctl_engine
(
    input  wire logic [31:0] crc_in,    // running checksum
    input  wire logic [31:0] data,      // data item, low bits used
    input  wire logic [1:0]  width,     // item width code
    input  wire logic [1:0]  poly_sel,  // polynomial select
    output logic      [31:0] crc_out    // checksum after the item
);

    function automatic logic [31:0] reflect32(input logic [31:0] v);
        logic [31:0] r;
        r = 32'h0;
        for (int k = 0; k < 32; k++)
            r[k] = v[31 - k];
        return r;
    endfunction : reflect32

    logic [5:0]  nbits;
    logic [31:0] poly_r;
    logic        fb;

    always_comb
    begin
        unique case (width)
            crcctl_pkg::WIDTH_BYTE: nbits = 6'h08;
            crcctl_pkg::WIDTH_HALF: nbits = 6'h10;
            default:                nbits = 6'h20;
        endcase
        unique case (poly_sel)
            crcctl_pkg::SEL_ISCSI32:
                poly_r = reflect32(crcctl_pkg::POLY_ISCSI32);
            crcctl_pkg::SEL_SIXTEEN_BIT:
                poly_r = reflect32({crcctl_pkg::POLY_SIXTEEN_BIT, 16'h0000});
            default:
                poly_r = reflect32(crcctl_pkg::POLY_ETHERNET32);
        endcase
        crc_out = crc_in;
        fb      = 1'b0;
        // bit 0 of the item first, up to its msb
        for (int i = 0; i < 32; i++)
        begin
            if (6'(i) < nbits)
            begin
                fb = crc_out[0] ^ data[i];
                if (poly_sel == crcctl_pkg::SEL_SIXTEEN_BIT)
                    crc_out[15:0] = {1'b0, crc_out[15:1]}
                                  ^ (fb ? poly_r[15:0] : 16'h0000);
                else
                    crc_out = {1'b0, crc_out[31:1]}
                            ^ (fb ? poly_r : 32'h0);
            end
        end
    end

endmodule : crcctl_engine

/* rtl/crcctl_pacer.sv */
`timescale 1ns/1ps

// one tick every 2^(divider+1) cycles while run is high
module crcctl_pacer
#(
    parameter int DIV_W = 4                 // divider field width
)
(
    input  wire logic             clk,      // bus clock
    input  wire logic             nrst,     // async reset, active low
    input  wire logic             run,      // count while high
    input  wire logic [DIV_W-1:0] divider,  // divider field
    output logic                  tick      // one-cycle request slot
);

    localparam int CW = (1 << DIV_W) + 1;

    logic [CW-1:0] cnt;
    logic [CW-1:0] limit;

    // a new divider value takes effect at once, on the count in progress
    assign limit = (CW'(1) << (32'(divider) + 1)) - CW'(1);
    assign tick  = run && (cnt == limit);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt <= '0;
        else if (!run || tick)
            cnt <= '0;
        else
            cnt <= cnt + CW'(1);
    end

endmodule : crcctl_pacer

/* rtl/crcctl_top.sv */
`timescale 1ns/1ps

// Function
// - writing one to dma enable-set bit 0 sets the dma mask bit
// - writing one to dma enable-clear bit 0 clears the dma mask bit
// - dma mask state reads the mask bit, zero after reset
// - dma done flag becomes one when a transfer completes
// - reading the dma done register clears the done flag
// - writing one to command bit 0 reloads the result initial value
// - divider field slows read requests by two to the power field plus one
// - poly select picks ethernet32, iscsi32 or the sixteen bit polynomial
// - compare bit enables comparing final checksum with the reference
// - enable bit permits computation; config resets to zero
// - result register shows the 32-bit checksum, reset to initial value
// - result reads zero while the compare bit is set
// - writing one to error enable-set bit 0 sets the error mask bit
// - writing one to error enable-clear bit 0 clears the error mask bit
// - error mask state reads the mask bit, zero after reset
// - the reader stops when the remaining count reaches zero
// - a compare mismatch sets mismatch status, interrupting if unmasked
// - reading the mismatch status register clears the mismatch flag
// - each data item is processed from lsb to msb
module crcctl_top
#(
    parameter int DIV_W   = 4,              // divider field width
    parameter int COUNT_W = 16              // transfer count width
)
(
    input  wire logic               clk,        // bus clock, 20 MHz
    input  wire logic               nrst,       // async reset, active low
    input  wire logic               psel,       // apb select
    input  wire logic               penable,    // apb access phase
    input  wire logic               pwrite,     // apb write
    input  wire logic [7:0]         paddr,      // apb byte address
    input  wire logic [31:0]        pwdata,     // apb write data
    output logic      [31:0]        prdata,     // apb read data
    output logic                    pready,     // apb ready
    output logic                    pslverr,    // apb error, unmapped
    input  wire logic               xfer_start, // reader starts a buffer
    input  wire logic [COUNT_W-1:0] xfer_count, // items in the buffer
    input  wire logic [1:0]         xfer_width, // item width code
    input  wire logic [31:0]        ref_crc,    // reference checksum
    output logic                    rd_req,     // request one item
    input  wire logic               rd_valid,   // item returned
    input  wire logic [31:0]        rd_data,    // item data
    output logic                    busy,       // transfer in progress
    output logic                    irq         // interrupt request
);

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic setup_rd;
    logic access_wr;
    logic access_rd;
    logic mapped;

    assign setup_rd  = psel && !penable && !pwrite;
    assign access_wr = psel && penable && pwrite;
    assign access_rd = psel && penable && !pwrite;
    assign pready    = 1'b1;

    always_comb
    begin
        unique case (paddr)
            crcctl_pkg::OFF_DMA_IER, crcctl_pkg::OFF_DMA_IDR,
            crcctl_pkg::OFF_DMA_IMR, crcctl_pkg::OFF_DMA_ISR,
            crcctl_pkg::OFF_COMMAND, crcctl_pkg::OFF_CONFIG,
            crcctl_pkg::OFF_RESULT,  crcctl_pkg::OFF_ERR_IER,
            crcctl_pkg::OFF_ERR_IDR, crcctl_pkg::OFF_ERR_IMR,
            crcctl_pkg::OFF_ERR_ISR: mapped = 1'b1;
            default:                 mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    logic wr_dma_ier;
    logic wr_dma_idr;
    logic wr_cmd;
    logic wr_cfg;
    logic wr_err_ier;
    logic wr_err_idr;

    assign wr_dma_ier = access_wr && paddr == crcctl_pkg::OFF_DMA_IER;
    assign wr_dma_idr = access_wr && paddr == crcctl_pkg::OFF_DMA_IDR;
    assign wr_cmd     = access_wr && paddr == crcctl_pkg::OFF_COMMAND;
    assign wr_cfg     = access_wr && paddr == crcctl_pkg::OFF_CONFIG;
    assign wr_err_ier = access_wr && paddr == crcctl_pkg::OFF_ERR_IER;
    assign wr_err_idr = access_wr && paddr == crcctl_pkg::OFF_ERR_IDR;

    // ----------------------------------------------------------------
    // configuration and masks
    // ----------------------------------------------------------------
    logic [7:0]       config_q;
    logic             dma_irq_mask_bit;
    logic             mismatch_irq_mask_bit;
    logic             cfg_enable;
    logic             cfg_compare;
    logic [1:0]       poly_select;
    logic [DIV_W-1:0] divider;

    assign cfg_enable  = config_q[crcctl_pkg::BIT_ENABLE];
    assign cfg_compare = config_q[crcctl_pkg::BIT_COMPARE];
    assign poly_select = config_q[crcctl_pkg::POLY_LSB +: 2];
    assign divider     = config_q[crcctl_pkg::DIV_LSB +: DIV_W];

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            config_q <= crcctl_pkg::CONFIG_RESET;
        else if (wr_cfg)
            config_q <= pwdata[7:0];
    end

    // a set and a clear in one cycle cannot happen: one bus access each
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            dma_irq_mask_bit <= 1'b0;
        else if (wr_dma_ier && pwdata[crcctl_pkg::MASK_BIT])
            dma_irq_mask_bit <= 1'b1;
        else if (wr_dma_idr && pwdata[crcctl_pkg::MASK_BIT])
            dma_irq_mask_bit <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mismatch_irq_mask_bit <= 1'b0;
        else if (wr_err_ier && pwdata[crcctl_pkg::MASK_BIT])
            mismatch_irq_mask_bit <= 1'b1;
        else if (wr_err_idr && pwdata[crcctl_pkg::MASK_BIT])
            mismatch_irq_mask_bit <= 1'b0;
    end

    // ----------------------------------------------------------------
    // transfer sequencer
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PACE,
        ST_READ,
        ST_FINISH
    } crcctl_state_t;

    crcctl_state_t    state;
    logic [COUNT_W-1:0] remaining_count;
    logic [1:0]       width_q;
    logic             tick;
    logic             take_item;

    assign take_item = state == ST_READ && rd_valid;
    assign rd_req    = state == ST_READ;
    assign busy      = state != ST_IDLE;

    crcctl_pacer #(.DIV_W(DIV_W)) u_pacer
    (
        .clk     (clk),
        .nrst    (nrst),
        .run     (state == ST_PACE && cfg_enable),
        .divider (divider),
        .tick    (tick)
    );

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state <= ST_IDLE;
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (xfer_start && cfg_enable)
                        state <= (xfer_count == '0) ? ST_FINISH : ST_PACE;
                ST_PACE:
                    if (tick)
                        state <= ST_READ;
                ST_READ:
                    if (rd_valid)
                        state <= (remaining_count == COUNT_W'(1))
                               ? ST_FINISH : ST_PACE;
                ST_FINISH:
                    state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            remaining_count <= '0;
            width_q         <= crcctl_pkg::WIDTH_BYTE;
        end
        else if (state == ST_IDLE && xfer_start && cfg_enable)
        begin
            remaining_count <= xfer_count;
            width_q         <= xfer_width;
        end
        else if (take_item)
            remaining_count <= remaining_count - COUNT_W'(1);
    end

    // ----------------------------------------------------------------
    // checksum
    // ----------------------------------------------------------------
    logic [31:0] checksum_result;
    logic [31:0] next_crc;

    crcctl_engine u_engine
    (
        .crc_in   (checksum_result),
        .data     (rd_data),
        .width    (width_q),
        .poly_sel (poly_select),
        .crc_out  (next_crc)
    );

    // reload wins over an item arriving in the same cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            checksum_result <= crcctl_pkg::RESULT_INIT;
        else if (wr_cmd && pwdata[crcctl_pkg::CMD_RELOAD])
            checksum_result <= crcctl_pkg::RESULT_INIT;
        else if (take_item && cfg_enable)
            checksum_result <= next_crc;
    end

    // ----------------------------------------------------------------
    // status flags, cleared on read; a new event wins over the clear
    // ----------------------------------------------------------------
    logic dma_done_status_bit;
    logic mismatch_status_bit;
    logic done_evt;
    logic mismatch_evt;
    logic seen_done;
    logic seen_mismatch;

    assign done_evt     = state == ST_FINISH;
    assign mismatch_evt = done_evt && cfg_compare
                        && checksum_result != ref_crc;

    // only a value that was shown in the setup phase is cleared
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            seen_done     <= 1'b0;
            seen_mismatch <= 1'b0;
        end
        else if (setup_rd)
        begin
            seen_done     <= dma_done_status_bit;
            seen_mismatch <= mismatch_status_bit;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            dma_done_status_bit <= 1'b0;
        else if (done_evt)
            dma_done_status_bit <= 1'b1;
        else if (access_rd && paddr == crcctl_pkg::OFF_DMA_ISR
                 && seen_done)
            dma_done_status_bit <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mismatch_status_bit <= 1'b0;
        else if (mismatch_evt)
            mismatch_status_bit <= 1'b1;
        else if (access_rd && paddr == crcctl_pkg::OFF_ERR_ISR
                 && seen_mismatch)
            mismatch_status_bit <= 1'b0;
    end

    assign irq = (dma_done_status_bit && dma_irq_mask_bit)
              || (mismatch_status_bit && mismatch_irq_mask_bit);

    // ----------------------------------------------------------------
    // read data, captured in the setup phase
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0;
        unique case (paddr)
            crcctl_pkg::OFF_DMA_IMR: rd_mux[0] = dma_irq_mask_bit;
            crcctl_pkg::OFF_DMA_ISR: rd_mux[0] = dma_done_status_bit;
            crcctl_pkg::OFF_CONFIG:  rd_mux[7:0] = config_q;
            // checksum hidden while compare is on
            crcctl_pkg::OFF_RESULT:
                rd_mux = cfg_compare ? 32'h0 : checksum_result;
            crcctl_pkg::OFF_ERR_IMR: rd_mux[0] = mismatch_irq_mask_bit;
            crcctl_pkg::OFF_ERR_ISR: rd_mux[0] = mismatch_status_bit;
            default:                 rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prdata <= 32'h0;
        else if (setup_rd)
            prdata <= rd_mux;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence set_dma_mask_s;
        wr_dma_ier && pwdata[0];
    endsequence

    sequence read_done_s;
        setup_rd && paddr == crcctl_pkg::OFF_DMA_ISR && dma_done_status_bit
        ##1 access_rd && !done_evt;
    endsequence

    dma_mask_set_a: assert property (
        @(posedge clk) disable iff (!nrst)
        set_dma_mask_s |=> dma_irq_mask_bit)
        else $error("dma mask not set by enable write");

    dma_mask_clr_a: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_dma_idr && pwdata[0] |=> !dma_irq_mask_bit)
        else $error("dma mask not cleared by disable write");

    done_read_clr_a: assert property (
        @(posedge clk) disable iff (!nrst)
        read_done_s |=> !dma_done_status_bit && prdata[0])
        else $error("done flag not cleared by read");

    done_set_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state == ST_READ && rd_valid && remaining_count == COUNT_W'(1)
        |=> ##1 dma_done_status_bit)
        else $error("done flag not set at end of transfer");

    reload_init_a: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_cmd && pwdata[0] |=> checksum_result == crcctl_pkg::RESULT_INIT)
        else $error("checksum not reloaded");

    result_hidden_a: assert property (
        @(posedge clk) disable iff (!nrst)
        setup_rd && paddr == crcctl_pkg::OFF_RESULT && cfg_compare
        |=> prdata == 32'h0)
        else $error("checksum visible while compare set");

    err_mask_a: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_err_ier && pwdata[0] ##1 !(wr_err_idr && pwdata[0])[*2]
        |-> mismatch_irq_mask_bit)
        else $error("error mask not held after set");

    mismatch_set_a: assert property (
        @(posedge clk) disable iff (!nrst)
        done_evt && cfg_compare && checksum_result != ref_crc
        |=> mismatch_status_bit)
        else $error("mismatch not flagged");

    no_compare_a: assert property (
        @(posedge clk) disable iff (!nrst)
        done_evt && !cfg_compare && !mismatch_status_bit
        |=> !mismatch_status_bit)
        else $error("mismatch flagged without compare");

    // tied to the finish step, so a lost done flag also trips it
    irq_level_a: assert property (
        @(posedge clk) disable iff (!nrst)
        done_evt && dma_irq_mask_bit ##1 dma_irq_mask_bit |-> irq)
        else $error("irq not raised by masked-in completion");

    pace_gap_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(state == ST_PACE) && divider == '0 && cfg_enable
        ##1 cfg_enable |=> state == ST_READ)
        else $error("request slot not after two cycles");

endmodule : crcctl_top

/* sim/crcctl_top_tb_top.sv */
`timescale 1ns/1ps

module crcctl_top_tb_top;
    logic        clk, nrst, psel, penable, pwrite, xfer_start, rd_valid;
    logic [7:0]  paddr, b;
    logic [31:0] pwdata, prdata, rd_data, ref_crc, seed, expc, d;
    logic        pready, pslverr, rd_req, busy, irq, err;
    logic [15:0] xfer_count;
    logic [1:0]  xfer_width;
    int          fails, compares, c0, c2;

    crcctl_top crcctl_top_i (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .xfer_start(xfer_start), .xfer_count(xfer_count),
        .xfer_width(xfer_width), .ref_crc(ref_crc), .rd_req(rd_req),
        .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .irq(irq));

    initial begin clk = 0; forever #25 clk = ~clk; end

    // ------------------------------------------------------------
    // expectation helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // reflected shift-right, so data bit 0 enters first
    function automatic logic [31:0] fold(input logic [31:0] c,
        input logic [31:0] v, input logic [1:0] w, input logic [1:0] s);
        logic [31:0] p, r;
        logic        f;
        p = (s == 2'h1) ? crcctl_pkg::POLY_ISCSI32 : (s == 2'h2) ?
            {16'h0, crcctl_pkg::POLY_SIXTEEN_BIT} : crcctl_pkg::POLY_ETHERNET32;
        r = 32'h0;
        for (int i = 0; i < ((s == 2'h2) ? 16 : 32); i++)
            r[i] = p[((s == 2'h2) ? 15 : 31) - i];
        for (int i = 0; i < ((w == 2'h0) ? 8 : (w == 2'h1) ? 16 : 32); i++)
        begin
            f = c[0] ^ v[i];
            if (s == 2'h2)
                c[15:0] = {1'b0, c[15:1]} ^ (f ? r[15:0] : 16'h0);
            else
                c = {1'b0, c[31:1]} ^ (f ? r : 32'h0);
        end
        return c;
    endfunction : fold

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // bus cycles, one idle cycle between accesses
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(negedge clk); psel = 1; pwrite = 1; paddr = a; pwdata = v;
        @(negedge clk); penable = 1;
        @(posedge clk);
        @(negedge clk); psel = 0; penable = 0; pwrite = 0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(negedge clk); psel = 1; pwrite = 0; paddr = a;
        @(negedge clk); penable = 1;
        @(posedge clk); v = prdata; err = pslverr;
        @(negedge clk); psel = 0; penable = 0;
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(v, exp);
    endtask : rdchk

    // cyc: cycles from start to the first item request
    task automatic run(input logic [3:0] dv, input logic [1:0] s,
        input logic cm, input int n, input logic flip, output int cyc);
        logic [1:0] w;
        int         k;
        wr(crcctl_pkg::OFF_CONFIG, {24'h0, dv, s, cm, 1'b1});
        seed = lfsr(seed);
        w = 2'(seed % 3);
        @(negedge clk); xfer_start = 1; xfer_count = 16'(n); xfer_width = w;
        @(negedge clk); xfer_start = 0; cyc = 0;
        for (int i = 0; i < n; i++)
        begin
            k = 0;
            while (rd_req !== 1'b1 && k < 300) begin @(negedge clk); k++; end
            if (i == 0) cyc = k;
            seed = lfsr(seed);
            expc = fold(expc, seed, w, s);
            ref_crc = expc ^ {31'h0, flip};
            rd_valid = 1; rd_data = seed;
            @(negedge clk); rd_valid = 0; rd_data = ~seed;
        end
        k = 0;
        while (busy !== 1'b0 && k < 300) begin @(negedge clk); k++; end
        @(negedge clk);
    endtask : run

    initial begin #3000000; fails++; results; end

    initial begin
        {nrst, psel, penable, pwrite, xfer_start, rd_valid} = 6'h0;
        {paddr, pwdata, rd_data, ref_crc, xfer_count, xfer_width} = 0;
        seed = 32'hb9dbd37f;
        repeat (20) @(negedge clk);
        nrst = 1;
        rdchk(crcctl_pkg::OFF_DMA_IMR, 32'h0);
        rdchk(crcctl_pkg::OFF_DMA_ISR, 32'h0);
        rdchk(crcctl_pkg::OFF_CONFIG, 32'h0);
        rdchk(crcctl_pkg::OFF_RESULT, crcctl_pkg::RESULT_INIT);
        rdchk(crcctl_pkg::OFF_ERR_IMR, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            b = i ? crcctl_pkg::OFF_ERR_IER : crcctl_pkg::OFF_DMA_IER;
            wr(b, 32'hfffffffe);
            rdchk(b + 8'h8, 32'h0);
            wr(b, 32'h1);
            rdchk(b + 8'h8, 32'h1);
            wr(b + 8'h4, 32'hfffffffe);
            rdchk(b + 8'h8, 32'h1);
            wr(b + 8'h4, 32'h1);
            rdchk(b + 8'h8, 32'h0);
            wr(b, 32'h1);
        end
        rd(8'h50, d);
        check(d, 32'h0);
        check({31'h0, err}, 32'h1);
        check({31'h0, pready}, 32'h1);
        seed = lfsr(seed);
        wr(crcctl_pkg::OFF_CONFIG, seed);
        rdchk(crcctl_pkg::OFF_CONFIG, {24'h0, seed[7:0]});
        wr(crcctl_pkg::OFF_COMMAND, 32'h1);
        expc = crcctl_pkg::RESULT_INIT;
        for (int s = 0; s < 3; s++)
        begin
            run(4'h0, 2'(s), 1'b0, 2, 1'b0, c0);
            rdchk(crcctl_pkg::OFF_RESULT, expc);
            check({31'h0, irq}, 32'h1);
            rdchk(crcctl_pkg::OFF_DMA_ISR, 32'h1);
            check({31'h0, irq}, 32'h0);
            rdchk(crcctl_pkg::OFF_DMA_ISR, 32'h0);
        end
        run(4'h0, 2'h0, 1'b0, 0, 1'b0, c0);
        rdchk(crcctl_pkg::OFF_DMA_ISR, 32'h1);
        run(4'h0, 2'h0, 1'b0, 1, 1'b0, c0);
        rd(crcctl_pkg::OFF_DMA_ISR, d);
        run(4'h2, 2'h0, 1'b0, 1, 1'b0, c2);
        check(32'(c2 - c0), 32'h6);
        wr(crcctl_pkg::OFF_COMMAND, 32'h1);
        expc = crcctl_pkg::RESULT_INIT;
        rdchk(crcctl_pkg::OFF_RESULT, crcctl_pkg::RESULT_INIT);
        run(4'h0, 2'h1, 1'b1, 1, 1'b1, c0);
        rdchk(crcctl_pkg::OFF_RESULT, 32'h0);
        rdchk(crcctl_pkg::OFF_DMA_ISR, 32'h1);
        check({31'h0, irq}, 32'h1);
        rdchk(crcctl_pkg::OFF_ERR_ISR, 32'h1);
        rdchk(crcctl_pkg::OFF_ERR_ISR, 32'h0);
        run(4'h0, 2'h1, 1'b1, 1, 1'b0, c0);
        rdchk(crcctl_pkg::OFF_ERR_ISR, 32'h0);
        run(4'h0, 2'h0, 1'b0, 1, 1'b1, c0);
        rdchk(crcctl_pkg::OFF_ERR_ISR, 32'h0);
        rdchk(crcctl_pkg::OFF_RESULT, expc);
        wr(crcctl_pkg::OFF_CONFIG, 32'h0);
        @(negedge clk); xfer_start = 1; xfer_count = 16'h1;
        @(negedge clk); xfer_start = 0;
        repeat (3) @(negedge clk);
        check({31'h0, busy}, 32'h0);
        results;
    end
endmodule : crcctl_top_tb_top
